/* File: bench/cbs_smb_host.sv */
`default_nettype none
module cbs_smb_host (
  // Bench clock
  input wire logic clk,
  // Bus wires
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // Quarter bit of 63 clocks keeps the bus just under 400 kHz
  localparam int Q = 63;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic qw(input int n);
    repeat (n * Q) @(posedge clk);
  endtask
  // Data falls while the clock is high
  task automatic start();
    sda_low <= 1'b1;
    qw(2);
    scl <= 1'b0;
    qw(1);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    qw(1);
    scl <= 1'b1;
    qw(1);
    sda_low <= 1'b0;
    qw(2);
  endtask
  // Data only changes while the clock is low; pull-up idles it high
  task automatic xfer(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= ~b[i];
      qw(1);
      scl <= 1'b1;
      qw(2);
      scl <= 1'b0;
      qw(1);
    end
    sda_low <= 1'b0;
    qw(1);
    scl <= 1'b1;
    qw(1);
    ack = ~sda;
    qw(1);
    scl <= 1'b0;
    qw(1);
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STAB = 20;
  localparam int DRV = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ref_clk = 1'b0;
  logic ref_run = 1'b1;
  logic [1:0] en_n = 2'h0;
  logic pg = 1'b0;
  logic [1:0] strap = 2'h0;
  logic scl, sda_low, oe, sda, sdo;
  logic [1:0] dp, dn, fm, bw;
  int mismatches = 0;
  int samples_checked = 0;
  // Open-drain wire with pull-up
  assign sda = ~(sda_low | (oe & ~sdo));
  always #5 clk = ~clk;
  // Gated so the bus can be starved of its reference
  always #40 if (ref_run) ref_clk = ~ref_clk;
  cbs_smb_host h (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
  cbs_clock_buffer_ctrl #(.STAB_CYC(STAB), .DRVPD_CYC(DRV)) dut (
    .CLK(clk), .RESET(rst), .SMB_CLK(scl), .SMB_DATA_IN(sda),
    .SMB_DATA_OUT(sdo), .SMB_DATA_OE(oe), .REF_CLK(ref_clk),
    .PAIR_ENABLE_N(en_n), .POWER_GOOD_POWERDOWN_N(pg),
    .BW_MODE_STRAP(strap), .DIFF_CLOCK_OUT_P(dp),
    .DIFF_CLOCK_OUT_N(dn), .FREQ_MODE(fm), .BW_MODE(bw));
  task automatic conclude();
    $display("mismatches=%0d samples_checked=%0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A pair is off only when both lines sit low
  task automatic await_pair(input int i, input logic on, input int lo,
                            input int hi);
    int c;
    c = 0;
    while ((dp[i] | dn[i]) !== on && c <= hi) begin
      @(posedge clk);
      c++;
    end
    if (c > hi) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, c, hi);
      conclude();
    end
    chk({7'h00, c >= lo}, 8'h01);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] n,
                    input logic [7:0] d0, input logic [7:0] d1);
    logic a;
    h.start();
    h.xfer(8'hDA, a);
    chk({7'h00, a}, 8'h01);
    h.xfer(idx, a);
    chk({7'h00, a}, 8'h01);
    h.xfer(n, a);
    chk({7'h00, a}, 8'h01);
    h.xfer(d0, a);
    chk({7'h00, a}, 8'h01);
    if (n == 8'h02) begin
      h.xfer(d1, a);
      chk({7'h00, a}, 8'h01);
    end
    h.stop();
    repeat (4) @(posedge clk);
  endtask
  task automatic probe(input logic [7:0] adr, input logic exp);
    logic a;
    h.start();
    h.xfer(adr, a);
    chk({7'h00, a}, {7'h00, exp});
    h.stop();
  endtask
  initial begin
    logic [7:0] d;
    logic [1:0] m;
    int i;
    logic a;
    i = $urandom(32'hE475_9794);
    strap <= 2'($urandom);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({6'h00, fm}, 8'h00);
    pg <= 1'b1;
    await_pair(0, 1'b1, STAB, STAB + 40);
    await_pair(1, 1'b1, 0, 40);
    chk({6'h00, dp ^ dn}, 8'h03);
    chk({6'h00, bw}, {6'h00, strap});
    for (int k = 0; k < 6; k++) begin
      i = $urandom_range(1, 0);
      repeat ($urandom_range(15, 0)) @(posedge clk);
      en_n[i] <= 1'b1;
      await_pair(i, 1'b0, 8, 30);
      en_n[i] <= 1'b0;
      await_pair(i, 1'b1, 8, 30);
    end
    // Two bytes per write prove the pointer steps to the next index
    for (int k = 0; k < 2; k++) begin
      d = 8'($urandom);
      m = 2'($urandom);
      wr(8'h00, 8'h02, d, {3'h1, m, 3'h0});
      chk({6'h00, dp[1] | dn[1], dp[0] | dn[0]},
          {6'h00, d[5], d[3]});
      chk({6'h00, bw}, {6'h00, m});
    end
    wr(8'h00, 8'h01, 8'hFF, 8'h00);
    wr(8'h03, 8'h01, 8'h18, 8'h00);
    chk({6'h00, fm}, 8'h00);
    m = 2'($urandom_range(2, 0));
    wr(8'h03, 8'h01, {3'h1, m, 3'h0}, 8'h00);
    chk({6'h00, fm}, {6'h00, m});
    // Index past the map is taken but not stored; surplus byte refused
    h.start();
    h.xfer(8'hDA, a);
    h.xfer(8'h0B, a);
    chk({7'h00, a}, 8'h01);
    h.xfer(8'h01, a);
    h.xfer({3'h1, ~m, 3'h0}, a);
    chk({7'h00, a}, 8'h01);
    h.xfer({3'h1, ~m, 3'h0}, a);
    chk({7'h00, a}, 8'h00);
    h.stop();
    repeat (4) @(posedge clk);
    chk({6'h00, fm}, {6'h00, m});
    probe(8'hDB, 1'b0);
    probe(8'hDC, 1'b0);
    ref_run <= 1'b0;
    repeat (100) @(posedge clk);
    probe(8'hDA, 1'b0);
    ref_run <= 1'b1;
    repeat (20) @(posedge clk);
    probe(8'hDA, 1'b1);
    pg <= 1'b0;
    await_pair(0, 1'b0, 0, 10);
    await_pair(1, 1'b0, 0, 10);
    repeat (30) @(posedge clk);
    pg <= 1'b1;
    await_pair(0, 1'b1, DRV, DRV + 40);
    conclude();
  end
endmodule
`default_nettype wire

/* File: rtl/cbs_cfg_if.sv */
`default_nettype none
interface cbs_cfg_if;
  logic we;
  logic [2:0] waddr;
  logic [7:0] wdata;
  logic [7:0] ctrl_oe;
  logic [7:0] ctrl_pll;
  logic [7:0] ctrl_fsel;

  modport mem (
    input we, waddr, wdata,
    output ctrl_oe, ctrl_pll, ctrl_fsel
  );
  modport ctl (
    output we, waddr, wdata,
    input ctrl_oe, ctrl_pll, ctrl_fsel
  );
endinterface
`default_nettype wire

/* File: rtl/cbs_cfg_mem.sv */
`include "cbs_defines.svh"
`default_nettype none
module cbs_cfg_mem (
  input wire logic clk,
  input wire logic rst,
  cbs_cfg_if.mem cfg
);
  logic [7:0] mem_q [8];

  function automatic logic [7:0] lane(input logic [63:0] v,
                                      input logic [2:0] i);
    lane = v[{i, 3'h0} +: 8];
  endfunction

  // Only writable fields change; identity bytes keep their reset values
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        mem_q[i] <= lane(`CBS_CFG_DEFAULTS, 3'(i));
      end
    end else if (cfg.we) begin
      mem_q[cfg.waddr] <= (mem_q[cfg.waddr]
        & ~lane(`CBS_CFG_WMASK, cfg.waddr))
        | (cfg.wdata & lane(`CBS_CFG_WMASK, cfg.waddr));
    end
  end

  assign cfg.ctrl_oe = mem_q[`CBS_IDX_OE];
  assign cfg.ctrl_pll = mem_q[`CBS_IDX_PLL];
  assign cfg.ctrl_fsel = mem_q[`CBS_IDX_FSEL];
endmodule
`default_nettype wire

/* File: rtl/cbs_clock_buffer_ctrl.sv */
`include "cbs_defines.svh"
`default_nettype none
// Contract
// - Pair starts or stops one to three output periods after its pin.
// - Enabled outputs drive within 300 us after power-down exit.
// - First output clock within 1 ms of start or power-down exit.
// - Serial interface answers only while the reference clock runs.
// - Frequency mode resets to 100 MHz; other modes only by writes.
// - Start plus own address with write bit is acknowledged.
// - Index byte is acknowledged and loaded as write pointer.
// - Byte count is acknowledged.
// - Count data bytes stored at consecutive indices, each acknowledged.
// - Device answers to address 1101101 plus direction bit; the code acknowledges only the write bit.
// - Active-low pair enable pins: low enables, high disables.
// - Cleared software enable bit forces that pair low, over the pin.
// - First power-good high latches straps; low powers down; high exits.
module cbs_clock_buffer_ctrl #(
  parameter int STAB_CYC = `CBS_STAB_CYC,
  parameter int DRVPD_CYC = `CBS_DRVPD_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Serial management pins
  input wire logic SMB_CLK,
  input wire logic SMB_DATA_IN,
  output logic SMB_DATA_OUT,
  output logic SMB_DATA_OE,
  // Reference clock and control pins
  input wire logic REF_CLK,
  input wire logic [1:0] PAIR_ENABLE_N,
  input wire logic POWER_GOOD_POWERDOWN_N,
  input wire logic [1:0] BW_MODE_STRAP,
  // Clock outputs and modes
  output logic [1:0] DIFF_CLOCK_OUT_P,
  output logic [1:0] DIFF_CLOCK_OUT_N,
  output logic [1:0] FREQ_MODE,
  output logic [1:0] BW_MODE
);
  cbs_cfg_if cfg ();
  cbs_cfg_mem u_mem (
    .clk(CLK),
    .rst(RESET),
    .cfg(cfg.mem)
  );

  // Three-stage input capture; stage one feeds stage two only
  localparam int NS = 8;
  logic [NS-1:0] s1_q, s2_q, s3_q, f_q, p_q;
  logic [NS-1:0] raw;
  assign raw = {BW_MODE_STRAP, POWER_GOOD_POWERDOWN_N, PAIR_ENABLE_N,
                REF_CLK, SMB_DATA_IN, SMB_CLK};
  always_ff @(posedge CLK) begin
    if (RESET) begin
      s1_q <= 8'h03;
      s2_q <= 8'h03;
      s3_q <= 8'h03;
      f_q <= 8'h03;
      p_q <= 8'h03;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= (s2_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
      p_q <= f_q;
    end
  end
  logic scl, sda, ref_lvl, pwrgd;
  logic [1:0] oe_n, strap;
  assign scl = f_q[0];
  assign sda = f_q[1];
  assign ref_lvl = f_q[2];
  assign oe_n = f_q[4:3];
  assign pwrgd = f_q[5];
  assign strap = f_q[7:6];
  logic scl_rise, scl_fall, start_c, stop_c, ref_rise;
  assign scl_rise = scl & ~p_q[0];
  assign scl_fall = ~scl & p_q[0];
  assign start_c = scl & p_q[0] & p_q[1] & ~sda;
  assign stop_c = scl & p_q[0] & ~p_q[1] & sda;
  assign ref_rise = ref_lvl & ~p_q[2];

  // Reference activity watchdog
  logic [7:0] ref_idle_q;
  logic ref_run_q;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ref_idle_q <= 8'h00;
      ref_run_q <= 1'b0;
    end else begin
      if (ref_rise) ref_idle_q <= 8'h00;
      else if (ref_idle_q != `CBS_REF_TIMEOUT) ref_idle_q <= ref_idle_q + 8'h01;
      ref_run_q <= ref_idle_q != `CBS_REF_TIMEOUT;
    end
  end

  // Serial slave
  cbs_pkg::cbs_smb_t smb_q;
  logic [7:0] shift_q, ptr_q, left_q;
  logic [3:0] bit_q;
  logic ack_q, we_q;
  logic [2:0] waddr_q;
  logic [7:0] wdata_q;
  logic byte_done;
  assign byte_done = scl_fall && !ack_q && bit_q == 4'h8;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      smb_q <= cbs_pkg::SMB_IDLE;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      left_q <= 8'h00;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      we_q <= 1'b0;
      waddr_q <= 3'h0;
      wdata_q <= 8'h00;
      SMB_DATA_OUT <= 1'b0;
    end else begin
      we_q <= 1'b0;
      SMB_DATA_OUT <= 1'b0;
      if (!ref_run_q || stop_c) begin
        smb_q <= cbs_pkg::SMB_IDLE;
        ack_q <= 1'b0;
      end else if (start_c) begin
        smb_q <= cbs_pkg::SMB_ADDR;
        bit_q <= 4'h0;
        ack_q <= 1'b0;
      end else if (scl_rise && !ack_q && bit_q != 4'h8) begin
        shift_q <= {shift_q[6:0], sda};
        bit_q <= bit_q + 4'h1;
      end else if (scl_fall && ack_q) begin
        ack_q <= 1'b0;
        bit_q <= 4'h0;
      end else if (byte_done) begin
        bit_q <= 4'h0;
        unique case (smb_q)
          cbs_pkg::SMB_ADDR: begin
            if (shift_q == {`CBS_SMB_ADDR, 1'b0}) begin
              ack_q <= 1'b1;
              smb_q <= cbs_pkg::SMB_INDEX;
            end else begin
              smb_q <= cbs_pkg::SMB_SKIP;
            end
          end
          cbs_pkg::SMB_INDEX: begin
            ptr_q <= shift_q;
            ack_q <= 1'b1;
            smb_q <= cbs_pkg::SMB_COUNT;
          end
          cbs_pkg::SMB_COUNT: begin
            left_q <= shift_q;
            ack_q <= 1'b1;
            smb_q <= cbs_pkg::SMB_DATA;
          end
          cbs_pkg::SMB_DATA: begin
            if (left_q != 8'h00) begin
              we_q <= ptr_q[7:3] == 5'h00;
              waddr_q <= ptr_q[2:0];
              wdata_q <= shift_q;
              ptr_q <= ptr_q + 8'h01;
              left_q <= left_q - 8'h01;
              ack_q <= 1'b1;
            end else begin
              smb_q <= cbs_pkg::SMB_SKIP;
            end
          end
          cbs_pkg::SMB_IDLE, cbs_pkg::SMB_SKIP: ;
        endcase
      end
    end
  end
  assign cfg.we = we_q;
  assign cfg.waddr = waddr_q;
  assign cfg.wdata = wdata_q;
  assign SMB_DATA_OE = ack_q;

  // Power sequencing; one counter serves both start-up waits
  cbs_pkg::cbs_pwr_t pwr_q;
  logic [16:0] stab_q;
  logic [1:0] strap_q;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pwr_q <= cbs_pkg::PWR_OFF;
      stab_q <= 17'h0_0000;
      strap_q <= 2'h0;
    end else begin
      unique case (pwr_q)
        cbs_pkg::PWR_OFF: if (pwrgd) begin
          strap_q <= strap;
          stab_q <= 17'(STAB_CYC - 1);
          pwr_q <= cbs_pkg::PWR_STAB;
        end
        cbs_pkg::PWR_STAB: begin
          if (!pwrgd) pwr_q <= cbs_pkg::PWR_DOWN;
          else if (stab_q == 17'h0_0000) pwr_q <= cbs_pkg::PWR_RUN;
          else stab_q <= stab_q - 17'h0_0001;
        end
        cbs_pkg::PWR_RUN: if (!pwrgd) pwr_q <= cbs_pkg::PWR_DOWN;
        cbs_pkg::PWR_DOWN: if (pwrgd) begin
          stab_q <= 17'(DRVPD_CYC - 1);
          pwr_q <= cbs_pkg::PWR_STAB;
        end
      endcase
    end
  end

  // Pair gating, counted in reference rising edges
  logic [1:0] sw_oe, want, gate_q;
  logic [1:0] lat_q [2];
  assign sw_oe = {cfg.ctrl_oe[`CBS_OE1_BIT], cfg.ctrl_oe[`CBS_OE0_BIT]};
  assign want = ~oe_n;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      gate_q <= 2'h0;
      lat_q[0] <= 2'h0;
      lat_q[1] <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (want[i] == gate_q[i]) begin
          lat_q[i] <= 2'h0;
        end else if (ref_rise) begin
          if (lat_q[i] == `CBS_OE_LAT_EDGES - 2'h1) begin
            gate_q[i] <= want[i];
            lat_q[i] <= 2'h0;
          end else begin
            lat_q[i] <= lat_q[i] + 2'h1;
          end
        end
      end
    end
  end

  // Outputs; a fast reference may alias at this sampling rate
  logic [1:0] drive;
  logic sw_freq, sw_bw;
  assign drive = gate_q & sw_oe & {2{pwr_q == cbs_pkg::PWR_RUN}};
  assign sw_freq = cfg.ctrl_fsel[`CBS_SWEN_BIT];
  assign sw_bw = cfg.ctrl_pll[`CBS_SWEN_BIT];
  always_ff @(posedge CLK) begin
    if (RESET) begin
      DIFF_CLOCK_OUT_P <= 2'h0;
      DIFF_CLOCK_OUT_N <= 2'h0;
      FREQ_MODE <= `CBS_FREQ_100;
      BW_MODE <= 2'h0;
    end else begin
      DIFF_CLOCK_OUT_P <= drive & {2{ref_lvl}};
      DIFF_CLOCK_OUT_N <= drive & {2{~ref_lvl}};
      FREQ_MODE <= sw_freq ?
        cfg.ctrl_fsel[`CBS_MODE_LSB +: 2] : `CBS_FREQ_100;
      BW_MODE <= sw_bw ? cfg.ctrl_pll[`CBS_MODE_LSB +: 2] : strap_q;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence pair_change_seq(int i);
    ref_rise && lat_q[i] == 2'h1 && want[i] != gate_q[i];
  endsequence
  a_pair0_latency: assert property ($changed(gate_q[0]) |->
    $past(ref_rise) && $past(lat_q[0]) == 2'h1)
    else $error("pair 0 gate changed off its latency edge");
  a_pair1_follow: assert property (pair_change_seq(1) |=>
    gate_q[1] == $past(want[1]))
    else $error("pair 1 gate did not follow its pin");
  a_pin_disable: assert property (oe_n[0] && !gate_q[0] |=>
    DIFF_CLOCK_OUT_P[0] == 1'b0 && DIFF_CLOCK_OUT_N[0] == 1'b0)
    else $error("disabled pair 0 still drives");
  a_sw_override: assert property (!sw_oe[1] |=>
    DIFF_CLOCK_OUT_P[1] == 1'b0 && DIFF_CLOCK_OUT_N[1] == 1'b0)
    else $error("software disable did not force pair 1 low");
  a_freq_default: assert property (!sw_freq |=>
    FREQ_MODE == `CBS_FREQ_100)
    else $error("frequency mode left 100 MHz without a write");
  a_stab_bound: assert property ((pwr_q == cbs_pkg::PWR_DOWN) && pwrgd |=>
    stab_q == 17'(DRVPD_CYC - 1) && pwr_q == cbs_pkg::PWR_STAB)
    else $error("power-down exit wait not loaded");
  a_powerdown_low: assert property (!pwrgd ##1 !pwrgd |-> ##2
    DIFF_CLOCK_OUT_P == 2'h0 && DIFF_CLOCK_OUT_N == 2'h0)
    else $error("outputs drive in power-down");
  a_no_ref_idle: assert property (!ref_run_q |=>
    smb_q == cbs_pkg::SMB_IDLE && !SMB_DATA_OE)
    else $error("serial slave active without reference");
  sequence own_addr_seq;
    byte_done && smb_q == cbs_pkg::SMB_ADDR
      && shift_q == {`CBS_SMB_ADDR, 1'b0};
  endsequence
  a_addr_ack: assert property (own_addr_seq |=>
    SMB_DATA_OE && smb_q == cbs_pkg::SMB_INDEX)
    else $error("own write address not acknowledged");
  a_data_write: assert property (byte_done && smb_q == cbs_pkg::SMB_DATA
    && left_q != 8'h00 |=> SMB_DATA_OE && ptr_q == $past(ptr_q) + 8'h01)
    else $error("data byte not acknowledged or pointer stuck");
endmodule
`default_nettype wire

/* File: rtl/cbs_defines.svh */
`ifndef CBS_DEFINES_SVH
`define CBS_DEFINES_SVH

// Bus address, seven bits
`define CBS_SMB_ADDR 7'h6D

// Clock rate and timing
`define CBS_CLK_MHZ 100
`define CBS_STAB_TYP_US 600
`define CBS_DRVPD_MAX_US 300
`define CBS_STAB_CYC (`CBS_STAB_TYP_US * `CBS_CLK_MHZ)
`define CBS_DRVPD_CYC (`CBS_DRVPD_MAX_US * `CBS_CLK_MHZ)
`define CBS_OE_LAT_EDGES 2'h2
`define CBS_REF_TIMEOUT 8'h40

// Configuration bytes, byte 7 in the top lane
`define CBS_CFG_DEFAULTS 64'h0800_00FF_C7FF_06FF
`define CBS_CFG_WMASK 64'h0000_0000_3928_3B28

// Byte indices and field positions
`define CBS_IDX_OE 3'h0
`define CBS_IDX_PLL 3'h1
`define CBS_IDX_FSEL 3'h3
`define CBS_OE0_BIT 3
`define CBS_OE1_BIT 5
`define CBS_SWEN_BIT 5
`define CBS_MODE_LSB 3
`define CBS_FREQ_100 2'h0

`endif

/* File: rtl/cbs_pkg.sv */
`default_nettype none
package cbs_pkg;
  typedef enum logic [5:0] {
    SMB_IDLE = 6'h01,
    SMB_ADDR = 6'h02,
    SMB_INDEX = 6'h04,
    SMB_COUNT = 6'h08,
    SMB_DATA = 6'h10,
    SMB_SKIP = 6'h20
  } cbs_smb_t;

  typedef enum logic [3:0] {
    PWR_OFF = 4'h1,
    PWR_STAB = 4'h2,
    PWR_RUN = 4'h4,
    PWR_DOWN = 4'h8
  } cbs_pwr_t;
endpackage
`default_nettype wire
